// ### bic_pkg.sv
package bic_pkg;

    // Register byte addresses
    localparam logic [7:0] IO_WIN_LO_OFF   = 8'h1c;
    localparam logic [7:0] IO_WIN_UP_OFF   = 8'h30;
    localparam logic [7:0] IRQ_CTRL_OFF    = 8'h3c;
    localparam logic [7:0] EVT_STATUS_OFF  = 8'h40;
    localparam logic [7:0] EVT_ENABLE_OFF  = 8'h44;
    localparam logic [7:0] EVT_CLEAR_OFF   = 8'h48;

    // Field positions in the dword at 3Ch
    localparam int IRQ_LINE_LSB   = 0;
    localparam int IRQ_PIN_LSB    = 8;
    localparam int PERR_RESP_BIT  = 16;
    localparam int SERR_FWD_BIT   = 17;
    localparam int ISA_BLOCK_BIT  = 18;
    localparam int VGA_FWD_BIT    = 19;
    localparam int RSVD_BIT       = 20;

    // Reset values
    localparam logic [7:0]  IRQ_LINE_RST  = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VAL   = 8'h00;
    localparam logic [3:0]  BCTL_RST      = 4'h0;
    localparam logic [7:0]  IO_BYTE_RST   = 8'h00;
    localparam logic [15:0] IO_UP_RST     = 16'h0000;

    // Event bits
    localparam int EVT_W          = 3;
    localparam int EVT_PERR       = 0;
    localparam int EVT_SERR       = 1;
    localparam int EVT_ISA_REFUSE = 2;

    // Address decode constants
    localparam logic [1:0]  ISA_ALIAS_ZERO = 2'h0;
    localparam logic [15:0] IO_TOP_ZERO    = 16'h0000;
    localparam logic [9:0]  VGA_IO_A_LO    = 10'h3b0;
    localparam logic [9:0]  VGA_IO_A_HI    = 10'h3bb;
    localparam logic [9:0]  VGA_IO_B_LO    = 10'h3c0;
    localparam logic [9:0]  VGA_IO_B_HI    = 10'h3df;
    localparam logic [31:0] VGA_MEM_LO     = 32'h000a_0000;
    localparam logic [31:0] VGA_MEM_HI     = 32'h000b_ffff;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // A transaction offered to the decoder
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [31:0] addr;
    } bic_req_s;

    // Decode answer
    typedef struct packed {
        logic valid;
        logic claim;
    } bic_ans_s;

endpackage : bic_pkg

// ### bic_bridge_ctrl.sv
`timescale 1ns/1ns
module bic_bridge_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,          // 100 MHz clock
    input  wire logic              aresetn,       // Sync reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,        // Write address
    input  wire logic              awvalid,       // Write address valid
    output logic                   awready,       // Write address ready
    input  wire logic [31:0]       wdata,         // Write data
    input  wire logic [3:0]        wstrb,         // Byte strobes
    input  wire logic              wvalid,        // Write data valid
    output logic                   wready,        // Write data ready
    output logic [1:0]             bresp,         // Write response
    output logic                   bvalid,        // Write response valid
    input  wire logic              bready,        // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,        // Read address
    input  wire logic              arvalid,       // Read address valid
    output logic                   arready,       // Read address ready
    output logic [31:0]            rdata,         // Read data
    output logic [1:0]             rresp,         // Read response
    output logic                   rvalid,        // Read data valid
    input  wire logic              rready,        // Read data ready
    input  wire bic_pkg::bic_req_s pri_req,       // Primary-side decode request
    output bic_pkg::bic_ans_s      pri_ans,       // Forward downstream
    input  wire bic_pkg::bic_req_s sec_req,       // Secondary-side I/O request
    output bic_pkg::bic_ans_s      sec_ans,       // Claim upstream
    input  wire logic              secondary_system_error_in_n, // Pin, active low
    input  wire logic              sec_parity_err_in_n,         // Pin, active low
    output logic                   pri_serr_out_n,  // Forwarded error, active low
    output logic                   sec_perr_report, // Parity error reported
    output logic                   irq              // Event interrupt, level
);

    logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]        bresp_reg, rresp_reg;
    logic [31:0]       rdata_reg, rdata_next;
    logic              rhit_next;
    logic              aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              do_write;
    logic              whit;

    logic [7:0]        irq_line_reg;
    logic [3:0]        bctl_reg;
    logic [7:0]        io_base_lo_reg, io_lim_lo_reg;
    logic [15:0]       io_base_up_reg, io_lim_up_reg;
    logic [bic_pkg::EVT_W-1:0] evt_status_reg, evt_enable_reg, evt_set;

    logic              serr_s1_reg, serr_s2_reg, serr_prev_reg;
    logic              perr_s1_reg, perr_s2_reg;
    logic [31:0]       io_base, io_limit;
    logic              pri_in_win, pri_isa_alias, pri_vga, sec_in_win, sec_isa_alias;
    logic              pri_isa_refuse;
    bic_pkg::bic_ans_s pri_ans_reg, sec_ans_reg;
    logic              pri_serr_n_reg, sec_perr_reg, irq_reg;

    logic perr_resp, serr_fwd, isa_block, vga_fwd;
    assign perr_resp = bctl_reg[0];
    assign serr_fwd  = bctl_reg[1];
    assign isa_block = bctl_reg[2];
    assign vga_fwd   = bctl_reg[3];

    assign awready         = awready_reg;
    assign wready          = wready_reg;
    assign bvalid          = bvalid_reg;
    assign bresp           = bresp_reg;
    assign arready         = arready_reg;
    assign rvalid          = rvalid_reg;
    assign rdata           = rdata_reg;
    assign rresp           = rresp_reg;
    assign pri_ans         = pri_ans_reg;
    assign sec_ans         = sec_ans_reg;
    assign pri_serr_out_n  = pri_serr_n_reg;
    assign sec_perr_report = sec_perr_reg;
    assign irq             = irq_reg;

    // Write channel: address and data taken in either order
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= bic_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
                wready_reg <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= whit ? bic_pkg::RESP_OKAY : bic_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    always_comb begin
        whit = 1'b1;
        case (awaddr_reg[7:0])
            bic_pkg::IO_WIN_LO_OFF, bic_pkg::IO_WIN_UP_OFF, bic_pkg::IRQ_CTRL_OFF,
            bic_pkg::EVT_STATUS_OFF, bic_pkg::EVT_ENABLE_OFF,
            bic_pkg::EVT_CLEAR_OFF: whit = 1'b1;
            default: whit = 1'b0;
        endcase
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_line_reg   <= bic_pkg::IRQ_LINE_RST;
            bctl_reg       <= bic_pkg::BCTL_RST;
            io_base_lo_reg <= bic_pkg::IO_BYTE_RST;
            io_lim_lo_reg  <= bic_pkg::IO_BYTE_RST;
            io_base_up_reg <= bic_pkg::IO_UP_RST;
            io_lim_up_reg  <= bic_pkg::IO_UP_RST;
            evt_enable_reg <= '0;
        end else if (do_write) begin
            case (awaddr_reg[7:0])
                bic_pkg::IRQ_CTRL_OFF: begin
                    if (wstrb_reg[0]) irq_line_reg <= wdata_reg[7:0];
                    // Bit 20 and pin byte not stored
                    if (wstrb_reg[2]) bctl_reg <= wdata_reg[19:16];
                end
                bic_pkg::IO_WIN_LO_OFF: begin
                    if (wstrb_reg[0]) io_base_lo_reg <= wdata_reg[7:0];
                    if (wstrb_reg[1]) io_lim_lo_reg  <= wdata_reg[15:8];
                end
                bic_pkg::IO_WIN_UP_OFF: begin
                    if (wstrb_reg[0]) io_base_up_reg[7:0]  <= wdata_reg[7:0];
                    if (wstrb_reg[1]) io_base_up_reg[15:8] <= wdata_reg[15:8];
                    if (wstrb_reg[2]) io_lim_up_reg[7:0]   <= wdata_reg[23:16];
                    if (wstrb_reg[3]) io_lim_up_reg[15:8]  <= wdata_reg[31:24];
                end
                bic_pkg::EVT_ENABLE_OFF: begin
                    if (wstrb_reg[0]) evt_enable_reg <= wdata_reg[bic_pkg::EVT_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // Read channel: one read at a time, data registered
    always_comb begin
        rdata_next = 32'h0000_0000;
        rhit_next  = 1'b1;
        case (araddr[7:0])
            bic_pkg::IRQ_CTRL_OFF: begin
                rdata_next[bic_pkg::IRQ_PIN_LSB +: 8]  = bic_pkg::IRQ_PIN_VAL;
                rdata_next[bic_pkg::IRQ_LINE_LSB +: 8] = irq_line_reg;
                rdata_next[bic_pkg::VGA_FWD_BIT:bic_pkg::PERR_RESP_BIT] = bctl_reg;
                rdata_next[bic_pkg::RSVD_BIT] = 1'b0;
            end
            bic_pkg::IO_WIN_LO_OFF:  rdata_next[15:0] = {io_lim_lo_reg, io_base_lo_reg};
            bic_pkg::IO_WIN_UP_OFF:  rdata_next = {io_lim_up_reg, io_base_up_reg};
            bic_pkg::EVT_STATUS_OFF: rdata_next[bic_pkg::EVT_W-1:0] = evt_status_reg;
            bic_pkg::EVT_ENABLE_OFF: rdata_next[bic_pkg::EVT_W-1:0] = evt_enable_reg;
            bic_pkg::EVT_CLEAR_OFF:  rdata_next = 32'h0000_0000;
            default:                 rhit_next = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= bic_pkg::RESP_OKAY;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rhit_next ? bic_pkg::RESP_OKAY : bic_pkg::RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Pin synchronisers; first stage read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serr_s1_reg   <= 1'b1;
            serr_s2_reg   <= 1'b1;
            serr_prev_reg <= 1'b1;
            perr_s1_reg   <= 1'b1;
            perr_s2_reg   <= 1'b1;
        end else begin
            serr_s1_reg   <= secondary_system_error_in_n;
            serr_s2_reg   <= serr_s1_reg;
            serr_prev_reg <= serr_s2_reg;
            perr_s1_reg   <= sec_parity_err_in_n;
            perr_s2_reg   <= perr_s1_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pri_serr_n_reg <= 1'b1;
            sec_perr_reg <= 1'b0;
        end else begin
            pri_serr_n_reg <= !(serr_fwd && !serr_s2_reg);
            sec_perr_reg <= perr_resp && !perr_s2_reg;
        end
    end

    // Window from base, limit and upper extensions; 4KB granularity
    assign io_base  = {io_base_up_reg, io_base_lo_reg[7:4], 12'h000};
    assign io_limit = {io_lim_up_reg, io_lim_lo_reg[7:4], 12'hfff};

    assign pri_in_win    = (pri_req.addr >= io_base) && (pri_req.addr <= io_limit);
    assign sec_in_win    = (sec_req.addr >= io_base) && (sec_req.addr <= io_limit);
    // Last 768 bytes of each 1KB block have address bits 9:8 nonzero
    assign pri_isa_alias = (pri_req.addr[31:16] == bic_pkg::IO_TOP_ZERO)
                        && (pri_req.addr[9:8] != bic_pkg::ISA_ALIAS_ZERO);
    assign sec_isa_alias = sec_req.addr[9:8] != bic_pkg::ISA_ALIAS_ZERO;
    assign pri_isa_refuse = pri_req.valid && pri_req.is_io && pri_in_win
                         && isa_block && pri_isa_alias;

    // VGA I/O decodes 10 bits below 64KB, as legacy adapters alias the rest
    always_comb begin
        if (pri_req.is_io) begin
            pri_vga = (pri_req.addr[31:16] == bic_pkg::IO_TOP_ZERO)
                   && (((pri_req.addr[9:0] >= bic_pkg::VGA_IO_A_LO)
                        && (pri_req.addr[9:0] <= bic_pkg::VGA_IO_A_HI))
                    || ((pri_req.addr[9:0] >= bic_pkg::VGA_IO_B_LO)
                        && (pri_req.addr[9:0] <= bic_pkg::VGA_IO_B_HI)));
        end else begin
            pri_vga = (pri_req.addr >= bic_pkg::VGA_MEM_LO)
                   && (pri_req.addr <= bic_pkg::VGA_MEM_HI);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pri_ans_reg <= '0;
            sec_ans_reg <= '0;
        end else begin
            pri_ans_reg.valid <= pri_req.valid;
            // VGA wins over windows; window forward when alias off
            pri_ans_reg.claim <= pri_req.valid && ((vga_fwd && pri_vga)
                              || (pri_req.is_io && pri_in_win && !pri_isa_refuse));
            sec_ans_reg.valid <= sec_req.valid;
            sec_ans_reg.claim <= sec_req.valid && sec_req.is_io
                              && (!sec_in_win || (isa_block && sec_isa_alias));
        end
    end

    // Events: set wins over a clear in the same cycle
    always_comb begin
        evt_set = '0;
        evt_set[bic_pkg::EVT_PERR]       = perr_resp && !perr_s2_reg;
        evt_set[bic_pkg::EVT_SERR]       = serr_fwd && !serr_s2_reg && serr_prev_reg;
        evt_set[bic_pkg::EVT_ISA_REFUSE] = pri_isa_refuse;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_reg <= '0;
            irq_reg        <= 1'b0;
        end else begin
            if (do_write && wstrb_reg[0] && awaddr_reg[7:0] == bic_pkg::EVT_CLEAR_OFF) begin
                evt_status_reg <= (evt_status_reg & ~wdata_reg[bic_pkg::EVT_W-1:0])
                                | evt_set;
            end else begin
                evt_status_reg <= evt_status_reg | evt_set;
            end
            irq_reg <= |(evt_status_reg & evt_enable_reg);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pin_zero_read: assert property (
        rvalid_reg && rresp_reg == bic_pkg::RESP_OKAY
        && $past(araddr[7:0]) == bic_pkg::IRQ_CTRL_OFF && $rose(rvalid_reg)
        |-> rdata_reg[15:8] == 8'h00 && !rdata_reg[20])
        else $error("pin byte or reserved bit read nonzero");
    a_line_write_kept: assert property (
        do_write && awaddr_reg[7:0] == bic_pkg::IRQ_CTRL_OFF && wstrb_reg[0]
        |=> irq_line_reg == $past(wdata_reg[7:0]))
        else $error("interrupt line write lost");
    a_perr_gated: assert property (
        !perr_resp |=> !sec_perr_reg)
        else $error("parity reported while disabled");
    a_serr_forward: assert property (
        serr_fwd && !serr_s2_reg ##1 serr_fwd |-> pri_serr_out_n == 1'b0)
        else $error("system error not forwarded");
    a_serr_blocked: assert property (
        !serr_fwd |=> pri_serr_out_n)
        else $error("system error forwarded while disabled");
    a_window_forward: assert property (
        pri_req.valid && pri_req.is_io && pri_in_win && !isa_block
        |=> pri_ans_reg.claim)
        else $error("window address not forwarded");
    a_isa_refuse: assert property (
        pri_isa_refuse && !(vga_fwd && pri_vga) |=> !pri_ans_reg.claim
        ##0 evt_status_reg[bic_pkg::EVT_ISA_REFUSE])
        else $error("alias address forwarded");
    a_isa_upstream: assert property (
        sec_req.valid && sec_req.is_io && isa_block && sec_isa_alias
        |=> sec_ans_reg.claim)
        else $error("alias not claimed upstream");
    a_vga_forward: assert property (
        pri_req.valid && vga_fwd && pri_vga |=> pri_ans_reg.claim)
        else $error("vga address not forwarded");
    a_rsvd_never: assert property (
        $rose(rvalid_reg) && $past(araddr[7:0]) == bic_pkg::IRQ_CTRL_OFF
        |-> !rdata_reg[bic_pkg::RSVD_BIT] && rdata_reg[31:21] == 11'h000)
        else $error("reserved bit set");
    a_irq_follow: assert property (
        |(evt_status_reg & evt_enable_reg) |=> irq_reg)
        else $error("interrupt not raised");

    c_write_done: cover property (do_write ##[1:4] (bvalid_reg && bready));
    c_isa_refuse: cover property (pri_isa_refuse);
    c_vga_io:     cover property (pri_req.valid && pri_req.is_io && vga_fwd && pri_vga);
    c_irq:        cover property ($rose(irq_reg));

endmodule : bic_bridge_ctrl

// ### bic_pci_peer.sv
`timescale 1ns/1ns
module bic_pci_peer (
    input  wire logic         go,       // Issue a transaction this cycle
    input  wire logic         io,       // I/O rather than memory space
    input  wire logic [31:0]  addr,     // Transaction address
    input  wire logic         serr_on,  // Assert the system error pin
    input  wire logic         perr_on,  // Assert the parity error pin
    output bic_pkg::bic_req_s pri_req,  // Primary-side request
    output bic_pkg::bic_req_s sec_req,  // Secondary-side request
    output logic              serr_n,   // System error pin, active low
    output logic              perr_n    // Parity error pin, active low
);
    // Released bus shows the inverse, so a stale address never looks valid
    assign pri_req = '{valid: go, is_io: go ? io : ~io, addr: go ? addr : ~addr};
    assign sec_req = pri_req;
    // Error pins idle high, driven low only while their enable is set
    assign serr_n  = ~serr_on;
    assign perr_n  = ~perr_on;
endmodule : bic_pci_peer

// ### bridge_irq_and_control_bits_tb.sv
`timescale 1ns/1ns
module bridge_irq_and_control_bits_tb;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [7:0]        awaddr = 8'h00;
    logic [7:0]        araddr = 8'h00;
    logic              awvalid = 1'b0;
    logic              wvalid = 1'b0;
    logic              bready = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready = 1'b0;
    logic [31:0]       wdata = 32'h0;
    logic [3:0]        wstrb = 4'hf;
    logic [31:0]       peer_addr = 32'h0;
    logic              peer_go = 1'b0;
    logic              peer_io = 1'b0;
    logic              serr_on = 1'b0;
    logic              perr_on = 1'b0;
    logic              exp_isa = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid, serr_n, perr_n;
    logic              pri_serr_out_n, sec_perr_report, irq, io;
    logic [1:0]        bresp, rresp, rs;
    logic [31:0]       rdata, rd, rnd, a;
    logic [2:0]        e;
    bic_pkg::bic_req_s pri_req, sec_req;
    bic_pkg::bic_ans_s pri_ans, sec_ans;
    int                n_mismatch = 0;
    int                n_tests = 0;
    int                cyc = 0;
    int                seed = 32'hec15;
    int                m;

    always #5 aclk = ~aclk;

    bic_pci_peer i_peer (.go(peer_go), .io(peer_io), .addr(peer_addr), .serr_on(serr_on),
        .perr_on(perr_on), .pri_req(pri_req), .sec_req(sec_req), .serr_n(serr_n),
        .perr_n(perr_n));

    bic_bridge_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pri_req(pri_req), .pri_ans(pri_ans), .sec_req(sec_req), .sec_ans(sec_ans),
        .secondary_system_error_in_n(serr_n), .sec_parity_err_in_n(perr_n),
        .pri_serr_out_n(pri_serr_out_n), .sec_perr_report(sec_perr_report), .irq(irq));

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && t < 50);
        rs = bresp;
        bready <= 1'b0;
        if (t >= 50) n_mismatch++;
    endtask : wr

    task automatic rdr(input logic [7:0] ad, output logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && t < 50);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (t >= 50) n_mismatch++;
    endtask : rdr

    // Returns refusal event, primary forward, secondary claim
    function automatic logic [2:0] dec(input logic i, input logic [31:0] x, input int md);
        logic win, isa, vga, low;
        low = x[31:16] == 16'h0;
        win = i && x >= 32'h0000_1000 && x <= 32'h0001_2fff;
        isa = md[0] && x[9:8] != 2'h0;
        vga = md[1] && (i ? low && ((x[9:0] >= 10'h3b0 && x[9:0] <= 10'h3bb)
            || (x[9:0] >= 10'h3c0 && x[9:0] <= 10'h3df))
            : x >= 32'h000a_0000 && x <= 32'h000b_ffff);
        return {win && isa && low, vga || (win && !(isa && low)), i && (isa || !win)};
    endfunction : dec

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h3c, rd);
        chk("ctrl reset", rd, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rdr(8'h3c, rd);
        chk("ctrl writable", rd, 32'h000f_00ff);
        // Only the line byte lane enabled
        wstrb <= 4'h1;
        wr(8'h3c, 32'h0000_0000);
        wstrb <= 4'hf;
        rdr(8'h3c, rd);
        chk("line lane only", rd, 32'h000f_0000);
        wr(8'h50, 32'h1);
        chk("unmapped wresp", rs, 32'h2);
        rdr(8'h50, rd);
        chk("unmapped rresp", rs, 32'h2);
        // Window 1000h..12FFFh straddles the 64KB line
        wr(8'h1c, 32'h0000_2010);
        wr(8'h30, 32'h0001_0000);
        wr(8'h44, 32'h7);
        rdr(8'h44, rd);
        chk("event enable", rd, 32'h7);
        for (m = 0; m < 4; m++) begin
            wr(8'h3c, 32'(m) << 18);
            for (int i = 0; i < 48; i++) begin
                rnd = $random(seed);
                a = (i % 8 == 0) ? 32'h3c4 : (i % 8 == 1) ? 32'ha1234 : {15'h0, rnd[16:0]};
                io = (i % 8 == 0) || ((i % 8 != 1) && rnd[20]);
                e = dec(io, a, m);
                if (e[2]) exp_isa = 1'b1;
                @(posedge aclk);
                peer_go <= 1'b1;
                peer_addr <= a;
                peer_io <= io;
                @(posedge aclk);
                peer_go <= 1'b0;
                @(negedge aclk);
                chk("pri claim", {pri_ans.valid, pri_ans.claim}, {1'b1, e[1]});
                chk("sec claim", {sec_ans.valid, sec_ans.claim}, {1'b1, e[0]});
            end
        end
        rdr(8'h40, rd);
        chk("refusal status", rd, {29'h0, exp_isa, 2'b00});
        chk("irq refusal", irq, exp_isa);
        wr(8'h48, 32'h7);
        rdr(8'h40, rd);
        chk("status cleared", rd, 32'h0);
        chk("irq cleared", irq, 1'b0);
        rdr(8'h48, rd);
        chk("clear reads zero", rd, 32'h0);
        perr_on <= 1'b1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk("parity ignored", sec_perr_report, 1'b0);
        rdr(8'h40, rd);
        chk("parity no event", rd, 32'h0);
        wr(8'h3c, 32'h0001_0000);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("parity reported", sec_perr_report, 1'b1);
        rdr(8'h40, rd);
        chk("parity event", rd, 32'h1);
        chk("irq parity", irq, 1'b1);
        wr(8'h44, 32'h0);
        rdr(8'h44, rd);
        chk("irq masked", irq, 1'b0);
        perr_on <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(8'h48, 32'h7);
        wr(8'h44, 32'h7);
        serr_on <= 1'b1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk("serr blocked", pri_serr_out_n, 1'b1);
        @(posedge aclk);
        serr_on <= 1'b0;
        wr(8'h3c, 32'h0002_0000);
        serr_on <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("serr forwarded", pri_serr_out_n, 1'b0);
        rdr(8'h40, rd);
        chk("serr event", rd, 32'h2);
        chk("irq serr", irq, 1'b1);
        serr_on <= 1'b0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("serr released", pri_serr_out_n, 1'b1);
        finish_test;
    end
endmodule : bridge_irq_and_control_bits_tb
